/* design/efiu_top.sv */
// Event flag interrupt unit with AXI4-Lite register access
// Function
// RQ1 - Two active-low open-drain interrupt outputs
// RQ2 - Eleven flags in two flag registers
// RQ3 - Per-flag enable bits in two registers
// RQ4 - Enabled flag latches on source rising edge
// RQ5 - Latched enabled flag pulls routed pin low
// RQ6 - Disabled flag mirrors source, no interrupt
// RQ7 - Writing one clears flag; zero ignored
// RQ8 - Hardware or soft reset clears flags
// RQ9 - Route bit picks first or second pin
// RQ10 - Each pin ORs its routed active flags
// RQ11 - Host reads flags after seeing interrupt
// RQ12 - Host follows documented service order
// RQ13 - Flag write also clears latched sources
// RQ14 - Pin releases when nothing active remains
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "efiu_map.svh"
module efiu_top
#(
  parameter int ADDR_W = 6
)
(
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       resetn,
  // AXI4-Lite write address
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [ADDR_W-1:0]          s_axi_awaddr,
  input  wire logic [2:0]                 s_axi_awprot,
  // AXI4-Lite write data
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  // AXI4-Lite write response
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  output logic [1:0]                      s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  input  wire logic [ADDR_W-1:0]          s_axi_araddr,
  input  wire logic [2:0]                 s_axi_arprot,
  // AXI4-Lite read data
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  // Event sources and clears toward latched sources
  input  wire logic [`EFIU_NUM_EVT-1:0]   evtSrc,
  output logic      [`EFIU_NUM_EVT-1:0]   evtSrcClear,
  // Interrupt pin A, open drain
  input  wire logic                       irqOutANIn,
  output logic                            irqOutANOut,
  output logic                            irqOutANOeN,
  // Interrupt pin B, open drain
  input  wire logic                       irqOutBNIn,
  output logic                            irqOutBNOut,
  output logic                            irqOutBNOeN
);
  import efiu_pkg::*;

  localparam int NE = `EFIU_NUM_EVT;

  // ************************************************************
  // Register storage
  // ************************************************************
  logic [`EFIU_LO_W-1:0] ienLo_ff;
  logic [`EFIU_HI_W-1:0] ienHi_ff;
  logic [`EFIU_LO_W-1:0] rteLo_ff;
  logic [`EFIU_HI_W-1:0] rteHi_ff;
  logic                  swRst_ff;
  logic [NE-1:0]         srcClr_ff;
  logic                  irqAOeN_ff;
  logic                  irqBOeN_ff;
  logic                  pinLow_ff;

  // ************************************************************
  // Bus channel state
  // ************************************************************
  efiu_wr_e   wrSt_ff;
  efiu_rd_e   rdSt_ff;
  efiu_wr_s   wrReq_ff;
  logic       awHeld_ff;
  logic       wHeld_ff;
  logic       awRdy_ff;
  logic       wRdy_ff;
  logic       arRdy_ff;
  logic [1:0] bResp_ff;
  logic [31:0] rData_ff;
  logic [1:0] rResp_ff;
  // Combinational helpers
  logic [NE-1:0] ien;
  logic [NE-1:0] rte;
  logic [NE-1:0] evtSync;
  logic [NE-1:0] latched;
  logic [NE-1:0] readBits;
  logic [NE-1:0] clrMask;
  logic [1:0]    pinSync;
  logic          awTake;
  logic          wTake;
  logic          doWrite;
  logic          wrHit;
  logic          wrLegal;
  logic [3:0]    rdIdx;
  logic          rdLegal;
  logic [7:0]    rdByte;
  logic          activeA;
  logic          activeB;

  assign ien = {ienHi_ff, ienLo_ff}; // RQ3
  assign rte = {rteHi_ff, rteLo_ff}; // RQ9

  // ************************************************************
  // Input synchronisers and flag cells
  // ************************************************************
  // Sources may come from other clock domains
  efiu_sync #(.WIDTH(NE)) u_evtSync
  (.core_clk(core_clk), .resetn(resetn), .asyncIn(evtSrc),
   .syncOut(evtSync));

  // Pin levels may be pulled low by other devices on the wire
  efiu_sync #(.WIDTH(2)) u_pinSync
  (.core_clk(core_clk), .resetn(resetn),
   .asyncIn({irqOutBNIn, irqOutANIn}), .syncOut(pinSync));

  // One cell per event; eleven in all across two registers
  genvar g;
  generate
    for (g = 0; g < NE; g++)
    begin : g_flag
      efiu_flag_cell u_cell // RQ2
      (.core_clk(core_clk), .resetn(resetn), .srcLevel(evtSync[g]),
       .enable(ien[g]), .clearW1c(clrMask[g]), .swReset(swRst_ff),
       .latched(latched[g]), .readBit(readBits[g]));
    end
  endgenerate

  // ************************************************************
  // Write channel
  // ************************************************************
  assign awTake  = s_axi_awvalid & awRdy_ff;
  assign wTake   = s_axi_wvalid & wRdy_ff;
  assign doWrite = (wrSt_ff == WR_DO);

  // Address and data are taken in either order and held apart
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      awHeld_ff <= 1'b0;
      wHeld_ff  <= 1'b0;
      awRdy_ff  <= 1'b0;
      wRdy_ff   <= 1'b0;
      wrReq_ff  <= '0;
    end
    else
    begin
      if (awTake)
      begin
        awHeld_ff    <= 1'b1;
        awRdy_ff     <= 1'b0;
        wrReq_ff.idx <= s_axi_awaddr[`EFIU_ADR_MSB:`EFIU_ADR_LSB];
      end
      else if (doWrite)
        awHeld_ff <= 1'b0;
      else if (!awHeld_ff && wrSt_ff == WR_IDLE)
        awRdy_ff <= 1'b1;
      if (wTake)
      begin
        wHeld_ff       <= 1'b1;
        wRdy_ff        <= 1'b0;
        wrReq_ff.data  <= s_axi_wdata[7:0];
        wrReq_ff.lane0 <= s_axi_wstrb[0];
      end
      else if (doWrite)
        wHeld_ff <= 1'b0;
      else if (!wHeld_ff && wrSt_ff == WR_IDLE)
        wRdy_ff <= 1'b1;
    end
  end

  // Unmapped indices answer with an error; the map is control plus one run
  assign wrHit = (wrReq_ff.idx == `EFIU_IDX_CTRL)
                 | ((wrReq_ff.idx >= `EFIU_IDX_IEN_LO)
                    & (wrReq_ff.idx <= `EFIU_IDX_PIN));
  assign wrLegal = wrHit & wrReq_ff.lane0;

  // Write sequencing: collect, perform, respond
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wrSt_ff  <= WR_IDLE;
      bResp_ff <= `EFIU_RESP_OKAY;
    end
    else
    begin
      case (wrSt_ff)
        WR_IDLE:
          if ((awHeld_ff | awTake) & (wHeld_ff | wTake))
            wrSt_ff <= WR_DO;
        WR_DO:
        begin
          wrSt_ff  <= WR_RESP;
          bResp_ff <= wrHit ? `EFIU_RESP_OKAY : `EFIU_RESP_SLVERR;
        end
        WR_RESP:
          if (s_axi_bready)
            wrSt_ff <= WR_IDLE;
        default:
          wrSt_ff <= WR_IDLE;
      endcase
    end
  end

  // Enables and routes are plain read/write registers; the high ones keep three bits
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ienLo_ff <= `EFIU_RST_BYTE;
      ienHi_ff <= `EFIU_RST_HI;
      rteLo_ff <= `EFIU_RST_BYTE;
      rteHi_ff <= `EFIU_RST_HI;
    end
    else if (doWrite && wrLegal)
    begin
      case (wrReq_ff.idx)
        `EFIU_IDX_IEN_LO: ienLo_ff <= wrReq_ff.data; // RQ3
        `EFIU_IDX_IEN_HI: ienHi_ff <= wrReq_ff.data[`EFIU_HI_W-1:0];
        `EFIU_IDX_RTE_LO: rteLo_ff <= wrReq_ff.data; // RQ9
        `EFIU_IDX_RTE_HI: rteHi_ff <= wrReq_ff.data[`EFIU_HI_W-1:0];
        default:          ;
      endcase
    end
  end

  // Write-one clear mask for the flag cells; zeros leave flags alone
  always_comb
  begin
    clrMask = '0;
    if (doWrite && wrLegal)
    begin
      if (wrReq_ff.idx == `EFIU_IDX_FLG_LO)
        clrMask[`EFIU_LO_W-1:0] = wrReq_ff.data; // RQ7
      if (wrReq_ff.idx == `EFIU_IDX_FLG_HI)
        clrMask[NE-1:`EFIU_LO_W] = wrReq_ff.data[`EFIU_HI_W-1:0]; // RQ7
    end
  end

  // Soft reset is a one-cycle pulse, self-clearing
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      swRst_ff <= 1'b0;
    else
      swRst_ff <= doWrite & wrLegal & (wrReq_ff.idx == `EFIU_IDX_CTRL)
                  & wrReq_ff.data[`EFIU_CTRL_SWRST]; // RQ8
  end

  // Latched sources elsewhere are cleared by the same write or a soft reset
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      srcClr_ff <= '0;
    else
      srcClr_ff <= clrMask | {NE{swRst_ff}}; // RQ13
  end

  // ************************************************************
  // Read channel
  // ************************************************************
  assign rdIdx = s_axi_araddr[`EFIU_ADR_MSB:`EFIU_ADR_LSB];

  // Flag reads show latched or live state per enable bit
  always_comb
  begin
    rdByte  = 8'h00;
    rdLegal = 1'b1;
    case (rdIdx)
      `EFIU_IDX_CTRL:   rdByte = 8'h00;
      `EFIU_IDX_IEN_LO: rdByte = ienLo_ff;
      `EFIU_IDX_IEN_HI: rdByte = {5'h00, ienHi_ff};
      `EFIU_IDX_FLG_LO: rdByte = readBits[`EFIU_LO_W-1:0];
      `EFIU_IDX_FLG_HI: rdByte = {5'h00, readBits[NE-1:`EFIU_LO_W]};
      `EFIU_IDX_RTE_LO: rdByte = rteLo_ff;
      `EFIU_IDX_RTE_HI: rdByte = {5'h00, rteHi_ff};
      `EFIU_IDX_PIN:    rdByte = {5'h00, pinLow_ff, pinSync};
      default:          rdLegal = 1'b0;
    endcase
  end

  // One read at a time; data is captured at the address edge
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdSt_ff  <= RD_IDLE;
      arRdy_ff <= 1'b0;
      rData_ff <= 32'h0000_0000;
      rResp_ff <= `EFIU_RESP_OKAY;
    end
    else
    begin
      case (rdSt_ff)
        RD_IDLE:
          if (s_axi_arvalid && arRdy_ff)
          begin
            rdSt_ff  <= RD_DATA;
            arRdy_ff <= 1'b0;
            rData_ff <= {24'h00_0000, rdByte};
            rResp_ff <= rdLegal ? `EFIU_RESP_OKAY : `EFIU_RESP_SLVERR;
          end
          else
            arRdy_ff <= 1'b1;
        RD_DATA:
          if (s_axi_rready)
            rdSt_ff <= RD_IDLE;
        default:
          rdSt_ff <= RD_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Interrupt pins
  // ************************************************************
  // Disabled flags never reach a pin, whatever their level
  assign activeA = |(latched & ien & ~rte); // RQ5 RQ6 RQ10
  assign activeB = |(latched & ien & rte);  // RQ5 RQ6 RQ10

  // Enable low means the pin is pulled low; high means released
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irqAOeN_ff <= 1'b1;
      irqBOeN_ff <= 1'b1;
      pinLow_ff  <= 1'b0;
    end
    else
    begin
      irqAOeN_ff <= ~activeA; // RQ1 RQ14
      irqBOeN_ff <= ~activeB; // RQ1 RQ14
      pinLow_ff  <= activeA | activeB;
    end
  end

  // Bus and pin outputs, taken from flip-flops apart from the fixed pin data bits
  assign s_axi_awready = awRdy_ff;
  assign s_axi_wready  = wRdy_ff;
  assign s_axi_bvalid  = wrSt_ff[1]; // Set only in WR_RESP
  assign s_axi_bresp   = bResp_ff;
  assign s_axi_arready = arRdy_ff;
  assign s_axi_rvalid  = (rdSt_ff == RD_DATA);
  assign s_axi_rdata   = rData_ff;
  assign s_axi_rresp   = rResp_ff;
  assign evtSrcClear   = srcClr_ff;
  // Open drain only ever drives low, so the data bit is fixed
  assign irqOutANOut   = 1'b0; // RQ1
  assign irqOutBNOut   = 1'b0; // RQ1
  assign irqOutANOeN   = irqAOeN_ff;
  assign irqOutBNOeN   = irqBOeN_ff;

endmodule // efiu_top

/* design/efiu_map.svh */
// Register indices, field positions and reset values of the event flag unit
`ifndef EFIU_MAP_SVH
`define EFIU_MAP_SVH

// Register indices; byte address is four times the index
`define EFIU_IDX_CTRL    4'h0
`define EFIU_IDX_IEN_LO  4'h3
`define EFIU_IDX_IEN_HI  4'h4
`define EFIU_IDX_FLG_LO  4'h5
`define EFIU_IDX_FLG_HI  4'h6
`define EFIU_IDX_RTE_LO  4'h7
`define EFIU_IDX_RTE_HI  4'h8
`define EFIU_IDX_PIN     4'h9

// Field layout
`define EFIU_NUM_EVT     11
`define EFIU_LO_W        8
`define EFIU_HI_W        3
`define EFIU_CTRL_SWRST  0
`define EFIU_ADR_MSB     5
`define EFIU_ADR_LSB     2

// Reset values
`define EFIU_RST_BYTE    8'h00
`define EFIU_RST_HI      3'h0

// AXI responses
`define EFIU_RESP_OKAY   2'b00
`define EFIU_RESP_SLVERR 2'b10

`endif

/* design/efiu_pkg.sv */
// Types shared by the event flag interrupt unit
package efiu_pkg;

  // One register write, as captured from the bus
  typedef struct packed {
    logic [3:0]  idx;
    logic [7:0]  data;
    logic        lane0;
  } efiu_wr_s;

  // Write channel sequencing
  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_DO   = 2'b01,
    WR_RESP = 2'b10
  } efiu_wr_e;

  // Read channel sequencing
  typedef enum logic {
    RD_IDLE = 1'b0,
    RD_DATA = 1'b1
  } efiu_rd_e;

endpackage

/* design/efiu_sync.sv */
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module efiu_sync
#(
  parameter int WIDTH = 1
)
(
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             resetn,
  // Asynchronous in, settled out
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] st1_ff;
  logic [WIDTH-1:0] st2_ff;
  logic [WIDTH-1:0] st3_ff;
  logic [WIDTH-1:0] settled_ff;

  // Stage one feeds stage two only, to keep metastability contained
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st1_ff     <= '0;
      st2_ff     <= '0;
      st3_ff     <= '0;
      settled_ff <= '0;
    end
    else
    begin
      st1_ff <= asyncIn;
      st2_ff <= st1_ff;
      st3_ff <= st2_ff;
      for (int i = 0; i < WIDTH; i++)
        if (st2_ff[i] == st3_ff[i])
          settled_ff[i] <= st3_ff[i];
    end
  end

  assign syncOut = settled_ff;

endmodule // efiu_sync

/* design/efiu_flag_cell.sv */
// One event flag: edge latch when enabled, live mirror when not
`timescale 1ns/1ps
module efiu_flag_cell
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic resetn,
  // Event source and controls
  input  wire logic srcLevel,
  input  wire logic enable,
  input  wire logic clearW1c,
  input  wire logic swReset,
  // Results
  output logic      latched,
  output logic      readBit
);

  logic prevLevel_ff;
  logic latched_ff;
  logic riseSeen;
  logic nxt_latched;

  // Only a rising edge counts, and only while enabled
  assign riseSeen = enable & srcLevel & ~prevLevel_ff; // RQ4

  // A set in the clear cycle wins; soft reset always empties the flag
  always_comb
  begin
    nxt_latched = latched_ff;
    if (clearW1c)
      nxt_latched = 1'b0; // RQ7
    if (riseSeen)
      nxt_latched = 1'b1; // RQ4
    if (swReset)
      nxt_latched = 1'b0; // RQ8
  end

  // Flag state and edge history
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prevLevel_ff <= 1'b0;
      latched_ff   <= 1'b0; // RQ8
    end
    else
    begin
      prevLevel_ff <= srcLevel;
      latched_ff   <= nxt_latched;
    end
  end

  assign latched = latched_ff;
  // Disabled flags show the live source
  assign readBit = enable ? latched_ff : srcLevel; // RQ6

endmodule // efiu_flag_cell

/* dv/efiu_top_assertions.sv */
// Port-level concurrent checks for the event flag interrupt unit
`timescale 1ns/1ps
`include "efiu_map.svh"
module efiu_top_assertions
(
  // Clock and reset
  input wire logic                     core_clk,
  input wire logic                     resetn,
  // Register bus handshakes
  input wire logic                     s_axi_awvalid,
  input wire logic                     s_axi_awready,
  input wire logic                     s_axi_wvalid,
  input wire logic                     s_axi_wready,
  input wire logic                     s_axi_bvalid,
  input wire logic                     s_axi_bready,
  input wire logic                     s_axi_arvalid,
  input wire logic                     s_axi_arready,
  input wire logic                     s_axi_rvalid,
  input wire logic                     s_axi_rready,
  // Source clears and pin data
  input wire logic [`EFIU_NUM_EVT-1:0] evtSrcClear,
  input wire logic                     irqOutANOut,
  input wire logic                     irqOutBNOut,
  input wire logic                     irqOutANOeN,
  input wire logic                     irqOutBNOeN
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // Address and data of one write taken at the same edge
  sequence wrTake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Any clear toward a latched source
  sequence clrPulse;
    (|evtSrcClear);
  endsequence

  AST_DRAIN_ONLY: assert property (!irqOutANOut && !irqOutBNOut)
    else $error("interrupt pin data is not low");
  AST_WR_ANSWER: assert property (wrTake |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  AST_WR_REFUSE: assert property (wrTake |=> !s_axi_awready && !s_axi_wready)
    else $error("write ready stayed high after take");
  AST_B_ONCE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  AST_READY_BACK: assert property ($fell(s_axi_bvalid) |-> ##[1:2]
    (s_axi_awready && s_axi_wready))
    else $error("write ready did not return");
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid)
    else $error("read data late");
  AST_R_ONCE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during read data");
  AST_CLR_PULSE: assert property (clrPulse |=> evtSrcClear == '0)
    else $error("source clear longer than one cycle");
  AST_CLR_CAUSE: assert property (clrPulse |->
    (s_axi_bvalid || $past(s_axi_bvalid)))
    else $error("source clear without a register write");
  AST_SOFT_RELEASE: assert property ((&evtSrcClear) |=>
    (irqOutANOeN && irqOutBNOeN))
    else $error("interrupt pin still pulled after soft reset");
endmodule // efiu_top_assertions

bind efiu_top efiu_top_assertions efiu_top_assertions_i (
  .core_clk, .resetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .evtSrcClear,
  .irqOutANOut, .irqOutBNOut, .irqOutANOeN, .irqOutBNOeN
);

/* dv/efiu_far_side.sv */
// Far side model: pin pull-ups and event sources that hold until cleared
`timescale 1ns/1ps
module efiu_far_side
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Pin drivers of the unit
  input  wire logic        aOut,
  input  wire logic        aOeN,
  input  wire logic        bOut,
  input  wire logic        bOeN,
  // Source stimulus and clears
  input  wire logic [10:0] liveLvl,
  input  wire logic [10:0] setLatch,
  input  wire logic [10:0] srcClear,
  // Resolved wires
  output logic             pinA,
  output logic             pinB,
  output logic      [10:0] srcOut
);
  logic [10:0] srcLatch_ff;

  // External pull-ups: a released pin reads high, never the last value
  assign pinA = aOeN ? 1'b1 : aOut;
  assign pinB = bOeN ? 1'b1 : bOut;

  // Held sources drop only when the unit clears them
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      srcLatch_ff <= 11'h000;
    else
      srcLatch_ff <= (srcLatch_ff & ~srcClear) | setLatch;
  end
  assign srcOut = liveLvl | srcLatch_ff;
endmodule // efiu_far_side

/* dv/event_flag_interrupt_unit_test.sv */
// Self-checking bench for the event flag interrupt unit
`timescale 1ns/1ps
`include "efiu_map.svh"
module event_flag_interrupt_unit_test;
  localparam logic [1:0] OK  = `EFIU_RESP_OKAY;
  localparam logic [1:0] ERR = `EFIU_RESP_SLVERR;
  localparam logic [3:0] CTL = `EFIU_IDX_CTRL;
  localparam logic [3:0] ENL = `EFIU_IDX_IEN_LO;
  localparam logic [3:0] ENH = `EFIU_IDX_IEN_HI;
  localparam logic [3:0] FLL = `EFIU_IDX_FLG_LO;
  localparam logic [3:0] FLH = `EFIU_IDX_FLG_HI;
  localparam logic [3:0] ROH = `EFIU_IDX_RTE_HI;
  localparam logic [3:0] PIN = `EFIU_IDX_PIN;
  logic        core_clk, resetn, awValid, awReady, wValid, wReady;
  logic        bValid, bReady, arValid, arReady, rValid, rReady;
  logic        aOut, aOeN, bOut, bOeN, pinA, pinB;
  logic [1:0]  bResp, rResp;
  logic [5:0]  awAddr, arAddr;
  logic [10:0] evtSrc, evtClr, liveLvl, setLatch;
  logic [31:0] wData, rData;
  int          failCount = 0;
  int          checkCount = 0;

  // Free-running core clock
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  efiu_top #(.ADDR_W(6)) efiu_top_i (
    .core_clk(core_clk), .resetn(resetn),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_awaddr(awAddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'h1),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_bresp(bResp),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_araddr(arAddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .evtSrc(evtSrc), .evtSrcClear(evtClr),
    .irqOutANIn(pinA), .irqOutANOut(aOut), .irqOutANOeN(aOeN),
    .irqOutBNIn(pinB), .irqOutBNOut(bOut), .irqOutBNOeN(bOeN)
  );

  efiu_far_side efiu_far_side_i (
    .core_clk(core_clk), .resetn(resetn), .aOut(aOut), .aOeN(aOeN),
    .bOut(bOut), .bOeN(bOeN), .liveLvl(liveLvl), .setLatch(setLatch),
    .srcClear(evtClr), .pinA(pinA), .pinB(pinB), .srcOut(evtSrc)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp)
    begin
      failCount++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Write one register; each channel is dropped at its own take edge
  task automatic wr(input logic [3:0] idx, input logic [7:0] d,
                    input logic [1:0] er);
    logic aw, w, b;
    int   n;
    aw = 1'b1;
    w = 1'b1;
    b = 1'b1;
    n = 0;
    @(posedge core_clk);
    awAddr  <= {idx, 2'b00};
    wData   <= {24'h0, d};
    awValid <= 1'b1;
    wValid  <= 1'b1;
    bReady  <= 1'b1;
    while ((aw || w || b) && n < 60)
    begin
      @(posedge core_clk);
      n++;
      if (b && bValid === 1'b1)
        chk({30'h0, bResp}, {30'h0, er});
      aw = aw && (awReady !== 1'b1);
      w = w && (wReady !== 1'b1);
      b = b && (bValid !== 1'b1);
      awValid <= aw;
      wValid  <= w;
      bReady  <= b;
    end
    chk({29'h0, aw, w, b}, 32'h0);
  endtask

  // Read one register and compare data and response
  task automatic rdc(input logic [3:0] idx, input logic [31:0] ed,
                     input logic [1:0] er);
    logic ar, r;
    int   n;
    ar = 1'b1;
    r = 1'b1;
    n = 0;
    @(posedge core_clk);
    arAddr  <= {idx, 2'b00};
    arValid <= 1'b1;
    rReady  <= 1'b1;
    while ((ar || r) && n < 60)
    begin
      @(posedge core_clk);
      n++;
      if (r && rValid === 1'b1)
      begin
        chk(rData, ed);
        chk({30'h0, rResp}, {30'h0, er});
      end
      ar = ar && (arReady !== 1'b1);
      r = r && (rValid !== 1'b1);
      arValid <= ar;
      rReady  <= r;
    end
    chk({30'h0, ar, r}, 32'h0);
  endtask

  // Pin levels once the enable update has landed
  task automatic pins(input logic ea, input logic eb);
    repeat (4) @(posedge core_clk);
    chk({30'h0, pinA, pinB}, {30'h0, ea, eb});
  endtask

  // Live source pulse long enough to pass the synchroniser
  task automatic pulse(input logic [10:0] m);
    @(posedge core_clk);
    liveLvl <= m;
    repeat (8) @(posedge core_clk);
    liveLvl <= 11'h000;
    repeat (12) @(posedge core_clk);
  endtask

  // Source that holds high until the unit clears it
  task automatic hold(input logic [10:0] m);
    @(posedge core_clk);
    setLatch <= m;
    @(posedge core_clk);
    setLatch <= 11'h000;
    repeat (12) @(posedge core_clk);
  endtask

  task automatic tReset();
    for (logic [3:0] i = ENL; i <= ROH; i++)
      rdc(i, 32'h0, OK);
    pins(1'b1, 1'b1);
    rdc(PIN, 32'h03, OK);
    wr(4'h2, 8'hff, ERR);
    rdc(4'h2, 32'h0, ERR);
    rdc(4'hf, 32'h0, ERR);
  endtask

  task automatic tMirror();
    @(posedge core_clk);
    liveLvl <= 11'h5a5;
    repeat (12) @(posedge core_clk);
    rdc(FLL, 32'ha5, OK);
    rdc(FLH, 32'h05, OK);
    pins(1'b1, 1'b1);
    pulse(11'h000);
    rdc(FLL, 32'h00, OK);
  endtask

  task automatic tLatch();
    wr(ENL, 8'hff, OK);
    wr(ENH, 8'h07, OK);
    wr(ROH, 8'h07, OK);
    pulse(11'h084);
    rdc(FLL, 32'h84, OK);
    pins(1'b0, 1'b1);
    rdc(PIN, 32'h06, OK);
    wr(FLL, 8'h00, OK);
    rdc(FLL, 32'h84, OK);
    wr(FLL, 8'h04, OK);
    pins(1'b0, 1'b1);
    wr(FLL, 8'h80, OK);
    pins(1'b1, 1'b1);
    pulse(11'h200);
    rdc(FLH, 32'h02, OK);
    pins(1'b1, 1'b0);
    wr(ENH, 8'h00, OK);
    pins(1'b1, 1'b1);
    wr(ENH, 8'h07, OK);
  endtask

  // Host service sequence on a source that the unit must clear
  task automatic tService();
    hold(11'h008);
    pins(1'b0, 1'b0);
    rdc(FLL, 32'h08, OK);
    wr(ENL, 8'hf7, OK);
    pins(1'b1, 1'b0);
    rdc(FLL, 32'h08, OK);
    wr(FLL, 8'h08, OK);
    // The held source drops one edge after the clear pulse
    @(posedge core_clk);
    chk({21'h0, evtSrc}, 32'h0);
    repeat (8) @(posedge core_clk);
    rdc(FLL, 32'h00, OK);
    wr(ENL, 8'hff, OK);
    pins(1'b1, 1'b0);
  endtask

  task automatic tSoft();
    hold(11'h001);
    wr(CTL, 8'h01, OK);
    // Soft reset pulses the source clear one edge later than a flag write
    repeat (2) @(posedge core_clk);
    chk({21'h0, evtSrc}, 32'h0);
    pins(1'b1, 1'b1);
    rdc(FLH, 32'h00, OK);
    rdc(ENH, 32'h07, OK);
  endtask

  task automatic tHard();
    pulse(11'h001);
    pins(1'b0, 1'b1);
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    rdc(ENL, 32'h00, OK);
    wr(ENL, 8'hff, OK);
    pins(1'b1, 1'b1);
  endtask

  task automatic endOfTest();
    $display("checks %0d mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    resetn = 1'b0;
    awValid = 1'b0;
    wValid = 1'b0;
    bReady = 1'b0;
    arValid = 1'b0;
    rReady = 1'b0;
    awAddr = 6'h00;
    arAddr = 6'h00;
    wData = 32'h0;
    liveLvl = 11'h000;
    setLatch = 11'h000;
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    tReset();
    tMirror();
    tLatch();
    tService();
    tSoft();
    tHard();
    endOfTest();
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge core_clk);
    failCount++;
    endOfTest();
  end
endmodule // event_flag_interrupt_unit_test
